// ==== core/i2c_reg_port.sv ====
`timescale 1ns/1ps
module i2c_reg_port
  import pmic_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Serial pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // Register side.
  reg_bus_if.port bus
);
  typedef struct packed {
    i2c_state_t st;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] f;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic oe;
  } port_state_t;

  port_state_t r_ff;
  port_state_t nxt_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign sda_oe = r_ff.oe;
  assign bus.addr = r_ff.ptr;
  assign bus.wdata = r_ff.sh;

  always_comb begin
    nxt_r = r_ff;
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    nxt_r.s1 = {sda_in, scl_in};
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    for (int i = 0; i < 2; i++) begin
      if (r_ff.s2[i] == r_ff.s3[i]) begin
        nxt_r.f[i] = r_ff.s3[i];
      end
    end
    scl_rise = nxt_r.f[0] & ~r_ff.f[0];
    scl_fall = ~nxt_r.f[0] & r_ff.f[0];
    start_c = r_ff.f[0] & nxt_r.f[0] & r_ff.f[1] & ~nxt_r.f[1];
    stop_c = r_ff.f[0] & nxt_r.f[0] & ~r_ff.f[1] & nxt_r.f[1];
    if (start_c) begin
      nxt_r.st = S_ADDR;
      nxt_r.bitc = 4'h0;
      nxt_r.oe = 1'b0;
    end else if (stop_c) begin
      nxt_r.st = S_IDLE;
      nxt_r.oe = 1'b0;
    end else if (scl_rise) begin
      nxt_r.bitc = r_ff.bitc + 4'h1;
      if (r_ff.st == S_ADDR || r_ff.st == S_REG || r_ff.st == S_WDATA) begin
        nxt_r.sh = {r_ff.sh[6:0], nxt_r.f[1]};
      end
      if (r_ff.st == S_ACK_R) begin
        nxt_r.nack = nxt_r.f[1];
      end
    end else if (scl_fall) begin
      case (r_ff.st)
        S_ADDR: begin
          if (r_ff.bitc == 4'h8) begin
            if (r_ff.sh[7:1] == I2C_ADDR_RST) begin
              nxt_r.oe = 1'b1;
              nxt_r.rw = r_ff.sh[0];
              nxt_r.st = S_ACK_A;
            end else begin
              nxt_r.st = S_IDLE;
            end
          end
        end
        S_ACK_A, S_ACK_R: begin
          if (r_ff.st == S_ACK_R && r_ff.nack) begin
            nxt_r.oe = 1'b0;
            nxt_r.st = S_IDLE;
          end else if (r_ff.rw) begin
            bus.rd = 1'b1;
            nxt_r.sh = bus.rdata;
            nxt_r.oe = ~bus.rdata[7];
            nxt_r.ptr = r_ff.ptr + 8'h01;
            nxt_r.bitc = 4'h0;
            nxt_r.st = S_RDATA;
          end else begin
            nxt_r.oe = 1'b0;
            nxt_r.bitc = 4'h0;
            nxt_r.st = S_REG;
          end
        end
        S_REG, S_WDATA: begin
          if (r_ff.bitc == 4'h8) begin
            nxt_r.oe = 1'b1;
            if (r_ff.st == S_REG) begin
              nxt_r.ptr = r_ff.sh;
              nxt_r.st = S_ACK_REG;
            end else begin
              bus.wr = 1'b1;
              nxt_r.ptr = r_ff.ptr + 8'h01;
              nxt_r.st = S_ACK_W;
            end
          end
        end
        S_ACK_REG, S_ACK_W: begin
          nxt_r.oe = 1'b0;
          nxt_r.bitc = 4'h0;
          nxt_r.st = S_WDATA;
        end
        S_RDATA: begin
          if (r_ff.bitc == 4'h8) begin
            nxt_r.oe = 1'b0;
            nxt_r.st = S_ACK_R;
          end else begin
            nxt_r.sh = {r_ff.sh[6:0], 1'b0};
            nxt_r.oe = ~r_ff.sh[6];
          end
        end
        default: begin
          nxt_r.st = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r_ff <= '{st: S_IDLE, s1: 2'h3, s2: 2'h3, s3: 2'h3, f: 2'h3,
                bitc: 4'h0, sh: 8'h00, ptr: 8'h00, rw: 1'b0, nack: 1'b0,
                oe: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end
endmodule : i2c_reg_port

// ==== core/pmic_event_irq_wake_control.sv ====
`timescale 1ns/1ps
// Functional notes
// - Converter starts disabled; enable bit D2 turns it on and off.
// - First enable waits a 2 ms warm-up before converting.
// - Writing start bit D3 from zero to one, with enable bit D2 set in the same write, begins a conversion.
// - Completion after 4 ms sets done bit D4 and the done source together.
// - Interrupt pin pulls low when any unmasked source is captured.
// - Bits 0 and 1 flag adapter connection and removal.
// - Bits 2 and 3 flag USB supply connection and removal.
// - Bit 4 flags the battery alarm level, 200 mV above cut-off.
// - Bit 5 flags the 115 C thermal alarm.
// - Bit 6 flags every finished conversion.
// - Bit 7 flags charger safety timer expiry.
// - Masked sources still latch but do not pull the pin.
// - Reading the flag register clears all flags.
// - Events during the clearing read wait in a hidden buffer.
// - Pending events keep the pin low through the clearing read.
// - Events are captured in standby and kept.
// - Above 160 C the device forces itself into standby.
// - Battery below threshold for 5 ms enters power-off unless the adapter is present.
// - Threshold is a factory code in 50 mV steps with hysteresis.
// - Adapter and USB deglitched 32 ms; adapter wakes except from standby during thermal shutdown.
// - USB with low battery waits until battery reaches the alarm level.
// - Wake bits record the wake source and clear on power-off.
// - System reset pin is low outside active mode.
module pmic_event_irq_wake_control
  import pmic_pkg::*;
#(
  parameter int WARMUP_P = WARMUP_CYC,
  parameter int CONV_P = CONV_CYC,
  parameter int BATLOW_P = BATLOW_CYC,
  parameter int DEGLITCH_P = DEGLITCH_CYC,
  parameter int ACK_P = ACK_CYC
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Serial register port.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Open-drain outputs.
  output logic irq_out_n,
  output logic irq_out_n_oe,
  output logic system_reset_out_n,
  output logic system_reset_out_n_oe,
  // Pin and comparator inputs.
  input wire logic adapter_input,
  input wire logic usb_supply_input,
  input wire logic power_button_input,
  input wire logic power_ack_pin,
  input wire logic battery_present,
  input wire logic battery_alarm_low,
  input wire logic battery_below_level,
  input wire logic thermal_alarm_hot,
  input wire logic thermal_shutdown_hot,
  input wire logic charge_timer_expired,
  // Converter front end.
  output logic adc_enable,
  output logic [1:0] adc_source,
  output logic adc_range,
  output logic adc_convert,
  input wire logic [7:0] adc_code,
  // Mode and trim.
  output logic active_mode,
  output logic [4:0] battery_low_level
);
  typedef struct packed {
    mode_t mode;
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
    logic [IN_W-1:0] flt;
    logic [1:0] det;
    logic [1:0][CNT_W-1:0] dg_cnt;
    logic [CNT_W-1:0] blo_cnt;
    logic [CNT_W-1:0] ack_cnt;
    logic [CNT_W-1:0] adc_cnt;
    logic adc_en;
    logic adc_start;
    logic adc_done;
    logic adc_rng;
    logic [1:0] adc_src;
    logic warm;
    logic busy;
    logic [7:0] result;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] pending;
    logic [4:0] wake;
    logic irq;
    logic rst_low;
  } ctl_state_t;

  ctl_state_t r_ff;
  ctl_state_t nxt_r;
  logic [7:0] ev;
  logic flag_rd;
  logic btn_edge;
  reg_bus_if bus ();

  i2c_reg_port port_u (
    .core_clk(core_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .bus(bus)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign sda_out = 1'b0;
  assign irq_out_n = 1'b0;
  assign irq_out_n_oe = r_ff.irq;
  assign system_reset_out_n = 1'b0;
  assign system_reset_out_n_oe = r_ff.rst_low;
  assign adc_enable = r_ff.adc_en;
  assign adc_source = r_ff.adc_src;
  assign adc_range = r_ff.adc_rng;
  assign adc_convert = r_ff.busy & r_ff.warm;
  assign active_mode = (r_ff.mode == M_ACTIVE);
  assign battery_low_level = BATLOW_CODE_RST;
  assign flag_rd = bus.rd & hit(bus.addr, FLAGS_OFF);

  always_comb begin
    case (1'b1)
      hit(bus.addr, ADC_CONTROL_STATUS_OFF): bus.rdata = {r_ff.adc_rng, 1'b0, r_ff.busy,
        r_ff.adc_done, r_ff.adc_start, r_ff.adc_en, r_ff.adc_src};
      hit(bus.addr, RESULT_OFF): bus.rdata = r_ff.result;
      hit(bus.addr, MASK_OFF): bus.rdata = r_ff.mask;
      hit(bus.addr, FLAGS_OFF): bus.rdata = r_ff.flags;
      hit(bus.addr, WAKE_OFF): bus.rdata = {3'h0, r_ff.wake};
      default: bus.rdata = 8'h00;
    endcase
  end

  always_comb begin
    nxt_r = r_ff;
    ev = 8'h00;
    nxt_r.s1 = {charge_timer_expired, thermal_shutdown_hot,
      thermal_alarm_hot, battery_below_level, battery_alarm_low,
      battery_present, power_ack_pin, power_button_input,
      usb_supply_input, adapter_input};
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    nxt_r.flt = (r_ff.s3 & ~(r_ff.s2 ^ r_ff.s3))
      | (r_ff.flt & (r_ff.s2 ^ r_ff.s3));
    btn_edge = nxt_r.flt[IN_BUTTON] & ~r_ff.flt[IN_BUTTON];
    for (int i = 0; i < 2; i++) begin
      if (r_ff.flt[i] == r_ff.det[i]) begin
        nxt_r.dg_cnt[i] = '0;
      end else if (r_ff.dg_cnt[i] == CNT_W'(DEGLITCH_P - 1)) begin
        nxt_r.dg_cnt[i] = '0;
        nxt_r.det[i] = r_ff.flt[i];
      end else begin
        nxt_r.dg_cnt[i] = r_ff.dg_cnt[i] + 1'b1;
      end
    end
    ev[0] = nxt_r.det[0] & ~r_ff.det[0];
    ev[1] = ~nxt_r.det[0] & r_ff.det[0];
    ev[2] = nxt_r.det[1] & ~r_ff.det[1];
    ev[3] = ~nxt_r.det[1] & r_ff.det[1];
    ev[4] = nxt_r.flt[IN_ALARM] & ~r_ff.flt[IN_ALARM];
    ev[5] = nxt_r.flt[IN_THALARM] & ~r_ff.flt[IN_THALARM];
    ev[7] = nxt_r.flt[IN_TIMER] & ~r_ff.flt[IN_TIMER];
    // Converter control, warm-up and conversion timing.
    if (bus.wr && hit(bus.addr, ADC_CONTROL_STATUS_OFF)) begin
      nxt_r.adc_en = bus.wdata[ADC_EN_BIT];
      nxt_r.adc_rng = bus.wdata[ADC_RANGE_BIT];
      nxt_r.adc_src = bus.wdata[ADC_SRC_LSB +: 2];
      nxt_r.adc_start = bus.wdata[ADC_START_BIT];
      if (bus.wdata[ADC_START_BIT] && !r_ff.adc_start
          && bus.wdata[ADC_EN_BIT]) begin
        nxt_r.busy = 1'b1;
        nxt_r.adc_done = 1'b0;
        if (r_ff.warm) begin
          nxt_r.adc_cnt = '0;
        end
      end
    end
    if (!nxt_r.adc_en) begin
      nxt_r.busy = 1'b0;
    end else if (!r_ff.warm) begin
      if (r_ff.adc_cnt == CNT_W'(WARMUP_P - 1)) begin
        nxt_r.warm = 1'b1;
        nxt_r.adc_cnt = '0;
      end else begin
        nxt_r.adc_cnt = r_ff.adc_cnt + 1'b1;
      end
    end else if (r_ff.busy) begin
      if (r_ff.adc_cnt == CNT_W'(CONV_P - 1)) begin
        nxt_r.busy = 1'b0;
        nxt_r.adc_done = 1'b1;
        nxt_r.result = adc_code;
        ev[6] = 1'b1;
      end else begin
        nxt_r.adc_cnt = r_ff.adc_cnt + 1'b1;
      end
    end
    if (bus.wr && hit(bus.addr, MASK_OFF)) begin
      nxt_r.mask = bus.wdata;
    end
    // Flags latch in every mode; a clearing read diverts new events.
    if (flag_rd) begin
      nxt_r.flags = 8'h00;
      nxt_r.pending = r_ff.pending | ev;
    end else begin
      nxt_r.flags = r_ff.flags | r_ff.pending | ev;
      nxt_r.pending = 8'h00;
    end
    nxt_r.irq = |((nxt_r.flags | nxt_r.pending) & ~r_ff.mask);
    // Battery-low filter and power-acknowledge deadline.
    if (r_ff.flt[IN_BELOW] && r_ff.blo_cnt != CNT_W'(BATLOW_P)) begin
      nxt_r.blo_cnt = r_ff.blo_cnt + 1'b1;
    end else if (!r_ff.flt[IN_BELOW]) begin
      nxt_r.blo_cnt = '0;
    end
    if (bus.wr && hit(bus.addr, WAKE_OFF)) begin
      nxt_r.wake[ACK_BIT] = bus.wdata[ACK_BIT];
    end
    if (r_ff.mode == M_ACTIVE && !r_ff.wake[ACK_BIT]
        && !r_ff.flt[IN_ACK]) begin
      nxt_r.ack_cnt = r_ff.ack_cnt + 1'b1;
    end
    case (r_ff.mode)
      M_OFF: begin
        if (r_ff.det[0]) begin
          nxt_r.mode = M_ACTIVE;
          nxt_r.wake[2] = 1'b1;
        end else if (r_ff.det[1] && !r_ff.flt[IN_ALARM]) begin
          nxt_r.mode = M_ACTIVE;
          nxt_r.wake[3] = 1'b1;
        end else if (r_ff.flt[IN_BATT] && !r_ff.flt[IN_ALARM]) begin
          nxt_r.mode = M_ACTIVE;
          nxt_r.wake[0] = 1'b1;
        end else if (r_ff.flt[IN_BATT] && !r_ff.flt[IN_BELOW]) begin
          nxt_r.mode = M_STANDBY;
        end
      end
      M_STANDBY: begin
        if (r_ff.blo_cnt == CNT_W'(BATLOW_P) && !r_ff.det[0]) begin
          nxt_r.mode = M_OFF;
        end else if (r_ff.flt[IN_THSD]) begin
          nxt_r.mode = M_STANDBY;
        end else if (r_ff.det[0]) begin
          nxt_r.mode = M_ACTIVE;
          nxt_r.wake[2] = 1'b1;
        end else if (r_ff.det[1] && !r_ff.flt[IN_ALARM]) begin
          nxt_r.mode = M_ACTIVE;
          nxt_r.wake[3] = 1'b1;
        end else if (btn_edge) begin
          nxt_r.mode = M_ACTIVE;
          nxt_r.wake[1] = 1'b1;
        end
      end
      M_ACTIVE: begin
        if (r_ff.flt[IN_THSD]) begin
          nxt_r.mode = M_STANDBY;
        end else if (r_ff.blo_cnt == CNT_W'(BATLOW_P) && !r_ff.det[0]) begin
          nxt_r.mode = M_OFF;
        end else if (r_ff.ack_cnt == CNT_W'(ACK_P)) begin
          nxt_r.mode = M_STANDBY;
        end
      end
      default: begin
        nxt_r.mode = M_OFF;
      end
    endcase
    if (nxt_r.mode != M_ACTIVE) begin
      nxt_r.ack_cnt = '0;
    end
    if (nxt_r.mode == M_OFF) begin
      nxt_r.wake = 5'h00;
    end
    nxt_r.rst_low = (nxt_r.mode != M_ACTIVE);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r_ff <= '0;
      r_ff.mode <= M_OFF;
      r_ff.mask <= MASK_RST;
      r_ff.flags <= FLAGS_RST;
      r_ff.rst_low <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  chk_adc_enable_write: assert property (@(posedge core_clk) disable iff (reset)
    $rose(adc_enable) |-> $past(bus.wr && hit(bus.addr, ADC_CONTROL_STATUS_OFF)))
    else $error("converter enabled without a control write");
  chk_done_raises_src: assert property (@(posedge core_clk) disable iff (reset)
    $rose(r_ff.adc_done) |-> (r_ff.flags[6] || r_ff.pending[6]))
    else $error("done bit set without the done source");
  chk_irq_asserts: assert property (@(posedge core_clk) disable iff (reset)
    (!flag_rd && !bus.wr && |((r_ff.flags | r_ff.pending) & ~r_ff.mask))
    |=> irq_out_n_oe)
    else $error("unmasked flag did not pull the interrupt pin");
  chk_masked_silent: assert property (@(posedge core_clk) disable iff (reset)
    (!bus.wr && ((r_ff.flags | r_ff.pending | ev) & ~r_ff.mask) == 8'h00)
    |=> !irq_out_n_oe)
    else $error("interrupt pin pulled with nothing unmasked");
  chk_read_clears: assert property (@(posedge core_clk) disable iff (reset)
    flag_rd |=> r_ff.flags == 8'h00)
    else $error("flag register not cleared by its read");
  chk_pending_moves: assert property (@(posedge core_clk) disable iff (reset)
    (flag_rd && ev != 8'h00) |-> ##2 ((r_ff.flags & $past(ev, 2))
    == $past(ev, 2)))
    else $error("event during clearing read was lost");
  chk_thermal_standby: assert property (@(posedge core_clk) disable iff (reset)
    (r_ff.mode == M_ACTIVE && r_ff.flt[IN_THSD]) |=> r_ff.mode == M_STANDBY)
    else $error("thermal shutdown did not force standby");
  chk_reset_out_low: assert property (@(posedge core_clk) disable iff (reset)
    (r_ff.mode != M_ACTIVE) |-> system_reset_out_n_oe)
    else $error("system reset released outside active mode");
  chk_wake_cleared: assert property (@(posedge core_clk) disable iff (reset)
    (r_ff.mode == M_OFF) |-> r_ff.wake == 5'h00)
    else $error("wake bits kept in power-off");
endmodule : pmic_event_irq_wake_control

// ==== core/pmic_pkg.sv ====
package pmic_pkg;
  // Core clock and timing figures.
  localparam int CLK_HZ = 10_000_000;
  localparam int WARMUP_MS = 2;
  localparam int CONV_MS = 4;
  localparam int BATLOW_MS = 5;
  localparam int DEGLITCH_MS = 32;
  localparam int ACK_MS = 128;
  localparam int WARMUP_CYC = (WARMUP_MS * CLK_HZ + 999) / 1000;
  localparam int CONV_CYC = (CONV_MS * CLK_HZ + 999) / 1000;
  localparam int BATLOW_CYC = (BATLOW_MS * CLK_HZ + 999) / 1000;
  localparam int DEGLITCH_CYC = (DEGLITCH_MS * CLK_HZ + 999) / 1000;
  localparam int ACK_CYC = ACK_MS * CLK_HZ / 1000;
  localparam int CNT_W = 21;

  // Register offsets.
  localparam logic [7:0] ADC_CONTROL_STATUS_OFF = 8'h0a;
  localparam logic [7:0] RESULT_OFF = 8'h0b;
  localparam logic [7:0] MASK_OFF = 8'h0c;
  localparam logic [7:0] FLAGS_OFF = 8'h0d;
  localparam logic [7:0] WAKE_OFF = 8'h0e;

  // Field positions.
  localparam int ADC_SRC_LSB = 0;
  localparam int ADC_EN_BIT = 2;
  localparam int ADC_START_BIT = 3;
  localparam int ADC_DONE_BIT = 4;
  localparam int ADC_BUSY_BIT = 5;
  localparam int ADC_RANGE_BIT = 7;
  localparam int ACK_BIT = 4;

  // Reset values.
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [6:0] I2C_ADDR_RST = 7'h30;
  localparam logic [4:0] BATLOW_CODE_RST = 5'h0a;

  // Synchronised pin inputs.
  localparam int IN_W = 10;
  localparam int IN_ADAPTER = 0;
  localparam int IN_USB = 1;
  localparam int IN_BUTTON = 2;
  localparam int IN_ACK = 3;
  localparam int IN_BATT = 4;
  localparam int IN_ALARM = 5;
  localparam int IN_BELOW = 6;
  localparam int IN_THALARM = 7;
  localparam int IN_THSD = 8;
  localparam int IN_TIMER = 9;

  typedef enum logic [2:0] {
    M_OFF = 3'b001,
    M_STANDBY = 3'b010,
    M_ACTIVE = 3'b100
  } mode_t;

  typedef enum logic [8:0] {
    S_IDLE = 9'b000000001,
    S_ADDR = 9'b000000010,
    S_ACK_A = 9'b000000100,
    S_REG = 9'b000001000,
    S_ACK_REG = 9'b000010000,
    S_WDATA = 9'b000100000,
    S_ACK_W = 9'b001000000,
    S_RDATA = 9'b010000000,
    S_ACK_R = 9'b100000000
  } i2c_state_t;
endpackage : pmic_pkg

// ==== core/reg_bus_if.sv ====
`timescale 1ns/1ps
interface reg_bus_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport port (output wr, output rd, output addr, output wdata,
                input rdata);
  modport regs (input wr, input rd, input addr, input wdata,
                output rdata);
endinterface : reg_bus_if

// ==== tb/host_cpu_model.sv ====
`timescale 1ns/1ps
module host_cpu_model
  import pmic_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Serial pins.
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic ack_seen;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // Data only moves while the clock is low.
  task automatic clk_bit(input logic b, output logic g);
    tick(4);
    sda_low = ~b;
    tick(8);
    scl = 1'b1;
    tick(6);
    g = sda;
    tick(6);
    scl = 1'b0;
  endtask : clk_bit

  task automatic start_cond();
    tick(4);
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b0;
    tick(8);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], g);
    end
    clk_bit(1'b1, ack_seen);
  endtask : send_byte

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    start_cond();
    send_byte({I2C_ADDR_RST, 1'b0});
    send_byte(off);
    send_byte(d);
    stop_cond();
  endtask : wr

  // The final bit is a not-acknowledge so the device lets go of the line.
  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    logic g;
    start_cond();
    send_byte({I2C_ADDR_RST, 1'b0});
    send_byte(off);
    start_cond();
    send_byte({I2C_ADDR_RST, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, g);
      d[i] = g;
    end
    clk_bit(1'b1, g);
    stop_cond();
  endtask : rd
endmodule : host_cpu_model

// ==== tb/pmic_event_irq_wake_control_test.sv ====
`timescale 1ns/1ps
module pmic_event_irq_wake_control_test
  import pmic_pkg::*;
();
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic adapter = 1'b0, usb = 1'b0, ack_pin = 1'b0, below = 1'b0;
  logic alarm = 1'b0, th_alarm = 1'b0, th_sd = 1'b0, timer = 1'b0;
  logic button = 1'b0, batt = 1'b0;
  logic conv, rng;
  logic [1:0] src;
  logic [4:0] bat_lvl;
  logic [7:0] code = 8'h5a;
  logic scl, sda_low, sda, sda_oe, irq_oe, rst_oe, adc_en, active;
  logic [7:0] got;
  int err_count = 0;
  int check_count = 0;

  assign sda = ~(sda_low | sda_oe);
  always #50 core_clk = ~core_clk;

  pmic_event_irq_wake_control #(.WARMUP_P(8), .CONV_P(10), .BATLOW_P(6),
    .DEGLITCH_P(5), .ACK_P(40)) pmic_event_irq_wake_control_i (
    .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .irq_out_n(), .irq_out_n_oe(irq_oe),
    .system_reset_out_n(), .system_reset_out_n_oe(rst_oe),
    .adapter_input(adapter), .usb_supply_input(usb),
    .power_button_input(button), .power_ack_pin(ack_pin),
    .battery_present(batt), .battery_alarm_low(alarm),
    .battery_below_level(below), .thermal_alarm_hot(th_alarm),
    .thermal_shutdown_hot(th_sd), .charge_timer_expired(timer),
    .adc_enable(adc_en), .adc_source(src), .adc_range(rng),
    .adc_convert(conv), .adc_code(code), .active_mode(active),
    .battery_low_level(bat_lvl));

  host_cpu_model host_cpu_model_i (.core_clk(core_clk), .scl(scl),
    .sda_low(sda_low), .sda(sda));

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check8

  // Select 0 waits on the interrupt pin, select 1 on the active mode.
  task automatic wait_on(input int sel, input logic v);
    for (int n = 0; n < 3000; n++) begin
      if (((sel == 0) ? irq_oe : active) === v) begin
        return;
      end
      @(negedge core_clk);
    end
    check8(8'hee, {7'h00, v});
    summarize();
  endtask : wait_on

  task automatic rdc(input logic [7:0] off, msk, e);
    host_cpu_model_i.rd(off, got);
    check8(got & msk, e);
  endtask : rdc

  task automatic wr(input logic [7:0] off, d);
    host_cpu_model_i.wr(off, d);
  endtask : wr

  task automatic t_reset();
    check8({5'h00, irq_oe, rst_oe, adc_en}, 8'h02);
    check8({3'h0, bat_lvl}, {3'h0, BATLOW_CODE_RST});
    rdc(MASK_OFF, 8'hff, MASK_RST);
    rdc(FLAGS_OFF, 8'hff, FLAGS_RST);
    rdc(8'h1f, 8'hff, 8'h00);
  endtask : t_reset

  task automatic t_adapter();
    ack_pin = 1'b1;
    adapter = 1'b1;
    wait_on(1, 1'b1);
    wait_on(0, 1'b1);
    check8({7'h00, rst_oe}, 8'h00);
    rdc(WAKE_OFF, 8'h0f, 8'h04);
    rdc(FLAGS_OFF, 8'hff, 8'h01);
    wait_on(0, 1'b0);
    rdc(FLAGS_OFF, 8'hff, 8'h00);
  endtask : t_adapter

  task automatic t_sources();
    for (int i = 0; i < 2; i++) begin
      {alarm, th_alarm} = 2'(1 << i);
      wait_on(0, 1'b1);
      rdc(FLAGS_OFF, 8'hff, (i == 0) ? 8'h20 : 8'h10);
      {alarm, th_alarm} = 2'b00;
      wait_on(0, 1'b0);
    end
    wr(MASK_OFF, 8'h0c);
    usb = 1'b1;
    repeat (12) @(negedge core_clk);
    check8({7'h00, irq_oe}, 8'h00);
    rdc(FLAGS_OFF, 8'hff, 8'h04);
    usb = 1'b0;
    repeat (12) @(negedge core_clk);
    rdc(FLAGS_OFF, 8'hff, 8'h08);
    wr(MASK_OFF, 8'h00);
  endtask : t_sources

  task automatic t_adc();
    wr(ADC_CONTROL_STATUS_OFF, 8'h8f);
    check8({7'h00, adc_en}, 8'h01);
    check8({5'h00, rng, src}, 8'h07);
    wait_on(0, 1'b1);
    rdc(ADC_CONTROL_STATUS_OFF, 8'hff, 8'h9f);
    rdc(FLAGS_OFF, 8'hff, 8'h40);
    wait_on(0, 1'b0);
    rdc(RESULT_OFF, 8'hff, 8'h5a);
    wr(ADC_CONTROL_STATUS_OFF, 8'h04);
    wr(ADC_CONTROL_STATUS_OFF, 8'h0c);
    wait_on(0, 1'b1);
    rdc(FLAGS_OFF, 8'hff, 8'h40);
    wr(ADC_CONTROL_STATUS_OFF, 8'h00);
    check8({6'h00, conv, adc_en}, 8'h00);
  endtask : t_adc

  // The alarm rises with the clock fall that loads and clears the flags.
  task automatic t_pending();
    fork
      rdc(FLAGS_OFF, 8'hff, 8'h00);
      begin
        repeat (696) @(negedge core_clk);
        th_alarm = 1'b1;
      end
    join
    wait_on(0, 1'b1);
    rdc(FLAGS_OFF, 8'hff, 8'h20);
    th_alarm = 1'b0;
  endtask : t_pending

  task automatic t_standby();
    th_sd = 1'b1;
    wait_on(1, 1'b0);
    check8({7'h00, rst_oe}, 8'h01);
    timer = 1'b1;
    wait_on(0, 1'b1);
    rdc(FLAGS_OFF, 8'hff, 8'h80);
    timer = 1'b0;
    adapter = 1'b0;
    repeat (12) @(negedge core_clk);
    th_sd = 1'b0;
    rdc(FLAGS_OFF, 8'hff, 8'h02);
    button = 1'b1;
    wait_on(1, 1'b1);
    rdc(WAKE_OFF, 8'h02, 8'h02);
    button = 1'b0;
    below = 1'b1;
    wait_on(1, 1'b0);
    rdc(WAKE_OFF, 8'h0f, 8'h00);
    below = 1'b0;
    repeat (12) @(negedge core_clk);
    batt = 1'b1;
    wait_on(1, 1'b1);
    rdc(WAKE_OFF, 8'h0f, 8'h01);
    ack_pin = 1'b0;
    wait_on(1, 1'b0);
  endtask : t_standby

  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_adapter();
    t_sources();
    t_adc();
    t_pending();
    t_standby();
    summarize();
  end
endmodule : pmic_event_irq_wake_control_test
